/* verilog/ppo_regs.svh */
`ifndef PPO_REGS_SVH
`define PPO_REGS_SVH
`define PPO_IDX_FEED_DIV 16'h60EE
`define PPO_IDX_POS_OPT 16'h60F2
`define PPO_SUB_COUNT 8'h00
`define PPO_SUB_OPT 8'h00
`define PPO_FB_COUNT 8'h03
`define PPO_DIV_RST 32'h00000001
`define PPO_OPT_RST 16'h0001
`define PPO_REL_LSB 0
`define PPO_RLS_LSB 4
`define PPO_RAD_LSB 6
`endif

/* verilog/ppo_pkg.sv */
package ppo_pkg;
  typedef enum logic [1:0] {
    PPO_REL_PREV = 2'h0,
    PPO_REL_RAMP = 2'h1,
    PPO_REL_ACT = 2'h2,
    PPO_REL_RSV = 2'h3
  } ppo_rel_t;
  typedef enum logic [1:0] {
    PPO_RLS_NONE = 2'h0,
    PPO_RLS_REACH = 2'h1,
    PPO_RLS_ASAP = 2'h2,
    PPO_RLS_RSV = 2'h3
  } ppo_rls_t;
  typedef enum logic [1:0] {
    PPO_RAD_LIN = 2'h0,
    PPO_RAD_NEG = 2'h1,
    PPO_RAD_POS = 2'h2,
    PPO_RAD_SHORT = 2'h3
  } ppo_rad_t;
  typedef enum logic [1:0] {
    PPO_SP_IDLE = 2'h0,
    PPO_SP_HELD = 2'h1,
    PPO_SP_REL = 2'h2
  } ppo_sp_t;
endpackage

/* verilog/ppo_divider.sv */
`timescale 1ns/1ns
`default_nettype none
module ppo_divider #(
  parameter int W = 32
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic [W-1:0] num_i,
  input wire logic [W-1:0] den_i,
  output logic busy_o,
  output logic done_o,
  output logic [W-1:0] quo_o
);
  localparam int CW = $clog2(W + 1);
  typedef struct packed {
    logic busy;
    logic done;
    logic [CW-1:0] cnt;
    logic [W-1:0] rem;
    logic [W-1:0] quo;
    logic [W-1:0] den;
  } ppo_div_st_t;
  ppo_div_st_t st_q;
  ppo_div_st_t st_d;
  logic [W:0] rem2;

  // restoring division, one quotient bit per cycle
  always_comb
  begin
    st_d = st_q;
    st_d.done = 1'b0;
    rem2 = {st_q.rem, st_q.quo[W-1]};
    if (!st_q.busy)
    begin
      if (start_i)
      begin
        st_d.busy = 1'b1;
        st_d.cnt = CW'(W);
        st_d.rem = '0;
        st_d.quo = num_i;
        st_d.den = den_i;
      end
    end
    else if (st_q.den == '0)
    begin
      // zero divisor saturates rather than hanging
      st_d.busy = 1'b0;
      st_d.done = 1'b1;
      st_d.quo = '1;
    end
    else
    begin
      if (rem2 >= {1'b0, st_q.den})
      begin
        st_d.rem = W'(rem2 - {1'b0, st_q.den});
        st_d.quo = {st_q.quo[W-2:0], 1'b1};
      end
      else
      begin
        st_d.rem = rem2[W-1:0];
        st_d.quo = {st_q.quo[W-2:0], 1'b0};
      end
      st_d.cnt = st_q.cnt - CW'(1);
      if (st_q.cnt == CW'(1))
      begin
        st_d.busy = 1'b0;
        st_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_q <= '0;
    else if (ce_i)
      st_q <= st_d;
  end

  assign busy_o = st_q.busy;
  assign done_o = st_q.done;
  assign quo_o = st_q.quo;
endmodule
`default_nettype wire

/* verilog/ppo_target.sv */
`timescale 1ns/1ns
`default_nettype none
module ppo_target #(
  parameter int W = 32
) (
  input wire logic rel_i,
  input wire ppo_pkg::ppo_rel_t rel_sel_i,
  input wire ppo_pkg::ppo_rad_t rad_sel_i,
  input wire logic signed [W-1:0] tgt_i,
  input wire logic signed [W-1:0] prev_i,
  input wire logic prev_vld_i,
  input wire logic signed [W-1:0] ramp_i,
  input wire logic signed [W-1:0] act_i,
  input wire logic signed [W-1:0] min_i,
  input wire logic signed [W-1:0] max_i,
  output logic signed [W-1:0] abs_o,
  output logic dir_pos_o,
  output logic via_o
);
  logic signed [W-1:0] span;
  logic signed [W-1:0] base;
  logic signed [W-1:0] raw;
  logic signed [W-1:0] diff;

  // target resolve, then range fold and direction choice
  always_comb
  begin
    span = max_i - min_i + W'(1);
    unique case (rel_sel_i)
      ppo_pkg::PPO_REL_RAMP: base = ramp_i;
      ppo_pkg::PPO_REL_ACT: base = act_i;
      default: base = prev_vld_i ? prev_i : '0;
    endcase
    raw = rel_i ? base + tgt_i : tgt_i;
    // a single fold: wraps the demand into the range in every direction mode
    abs_o = raw;
    if (raw > max_i)
      abs_o = raw - span;
    else if (raw < min_i)
      abs_o = raw + span;
    diff = abs_o - act_i;
    if (diff < 0)
      diff = diff + span;
    dir_pos_o = abs_o >= act_i;
    via_o = (raw > max_i) || (raw < min_i);
    unique case (rad_sel_i)
      ppo_pkg::PPO_RAD_NEG:
      begin
        dir_pos_o = 1'b0;
        via_o = abs_o > act_i;
      end
      ppo_pkg::PPO_RAD_POS:
      begin
        dir_pos_o = 1'b1;
        via_o = abs_o < act_i;
      end
      ppo_pkg::PPO_RAD_SHORT:
      begin
        dir_pos_o = (diff <<< 1) < span;
        via_o = dir_pos_o ? (abs_o < act_i) : (abs_o > act_i);
      end
      default:
      begin
      end
    endcase
  end
endmodule
`default_nettype wire

/* verilog/ppo_options.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ppo_regs.svh"
module ppo_options #(
  parameter int FB = `PPO_FB_COUNT
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic od_req_i,
  input wire logic od_we_i,
  input wire logic [15:0] od_index_i,
  input wire logic [7:0] od_sub_i,
  input wire logic [31:0] od_wdata_i,
  output logic od_ack_o,
  output logic od_err_o,
  output logic [31:0] od_rdata_o,
  input wire logic pp_mode_i,
  input wire logic ctrl_new_sp_i,
  input wire logic ctrl_rel_i,
  input wire logic sp_ready_i,
  input wire logic target_reached_i,
  input wire logic signed [31:0] target_pos_i,
  input wire logic signed [31:0] ramp_out_i,
  input wire logic signed [31:0] actual_pos_i,
  input wire logic signed [31:0] range_min_i,
  input wire logic signed [31:0] range_max_i,
  input wire logic [FB-1:0][31:0] feed_i,
  input wire logic [FB-1:0][31:0] motor_rev_i,
  input wire logic [FB-1:0][31:0] drive_rev_i,
  output logic sp_ack_o,
  output logic nsp_clear_o,
  output logic signed [31:0] demand_target_o,
  output logic dir_pos_o,
  output logic via_limit_o,
  output logic [FB-1:0][31:0] feed_const_o,
  output logic [FB-1:0][31:0] gear_ratio_o
);
  localparam int JW = $clog2(2 * FB);
  localparam logic [15:0] OPT_RST = `PPO_OPT_RST;
  typedef struct packed {
    logic [FB-1:0][31:0] div;
    logic [15:0] opt;
    ppo_pkg::ppo_rel_t rel;
    ppo_pkg::ppo_rls_t rls;
    ppo_pkg::ppo_rad_t rad;
    ppo_pkg::ppo_sp_t sp;
    logic nsp_prev;
    logic ack;
    logic clr;
    logic [31:0] prev;
    logic prev_vld;
    logic [31:0] dem;
    logic dir;
    logic via;
    logic [JW-1:0] job;
    logic start;
    logic [FB-1:0][31:0] feed;
    logic [FB-1:0][31:0] gear;
    logic [31:0] rdata;
    logic rack;
    logic rerr;
  } ppo_opt_st_t;
  ppo_opt_st_t st_q;
  ppo_opt_st_t st_d;
  logic div_done;
  logic [31:0] div_quo;
  logic [31:0] div_num;
  logic [31:0] div_den;
  logic [JW-1:0] gj;
  logic signed [31:0] t_abs;
  logic t_dir;
  logic t_via;
  logic hit_div;
  logic hit_opt;
  logic sub_ok;
  logic [7:0] si;
  logic [15:0] wopt;
  logic acc;

  // one shared divider walks feed jobs, then gear jobs
  always_comb
  begin
    gj = st_q.job - JW'(FB);
    if (st_q.job < JW'(FB))
    begin
      div_num = feed_i[st_q.job];
      div_den = st_q.div[st_q.job];
    end
    else
    begin
      div_num = motor_rev_i[gj];
      div_den = drive_rev_i[gj];
    end
  end

  ppo_divider #(
    .W(32)
  ) u_div (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .start_i(st_q.start),
    .num_i(div_num),
    .den_i(div_den),
    .busy_o(),
    .done_o(div_done),
    .quo_o(div_quo)
  );

  ppo_target #(
    .W(32)
  ) u_tgt (
    .rel_i(ctrl_rel_i),
    .rel_sel_i(st_q.rel),
    .rad_sel_i(st_q.rad),
    .tgt_i(target_pos_i),
    .prev_i(st_q.prev),
    .prev_vld_i(st_q.prev_vld),
    .ramp_i(ramp_out_i),
    .act_i(actual_pos_i),
    .min_i(range_min_i),
    .max_i(range_max_i),
    .abs_o(t_abs),
    .dir_pos_o(t_dir),
    .via_o(t_via)
  );

  // dictionary decode
  assign hit_div = od_index_i == `PPO_IDX_FEED_DIV;
  assign hit_opt = od_index_i == `PPO_IDX_POS_OPT;
  assign sub_ok = (od_sub_i != 8'h00) && (od_sub_i <= 8'(FB));
  assign si = od_sub_i - 8'h01;
  assign wopt = od_wdata_i[15:0];
  assign acc = pp_mode_i && ctrl_new_sp_i && !st_q.nsp_prev && sp_ready_i
               && st_q.sp == ppo_pkg::PPO_SP_IDLE;

  always_comb
  begin
    st_d = st_q;
    st_d.start = 1'b0;
    st_d.clr = 1'b0;
    st_d.rack = 1'b0;
    st_d.rerr = 1'b0;
    st_d.nsp_prev = ctrl_new_sp_i;
    // results land per job; loop keeps them tracking inputs
    if (div_done)
    begin
      if (st_q.job < JW'(FB))
        st_d.feed[st_q.job] = div_quo;
      else
        st_d.gear[gj] = div_quo;
      st_d.job = (st_q.job == JW'(2 * FB - 1)) ? '0 : st_q.job + JW'(1);
      st_d.start = 1'b1;
    end
    // register access, answered one cycle later
    if (od_req_i)
    begin
      st_d.rack = 1'b1;
      st_d.rdata = '0;
      if (hit_div && od_sub_i == `PPO_SUB_COUNT)
      begin
        if (od_we_i)
          st_d.rerr = 1'b1;
        else
          st_d.rdata = 32'(FB);
      end
      else if (hit_div && sub_ok)
      begin
        if (od_we_i)
          st_d.div[si] = od_wdata_i;
        else
          st_d.rdata = st_q.div[si];
      end
      else if (hit_opt && od_sub_i == `PPO_SUB_OPT)
      begin
        if (od_we_i)
        begin
          st_d.opt = wopt;
          // reserved codes are stored but never become active
          if (wopt[`PPO_REL_LSB +: 2] != 2'h3)
            st_d.rel = ppo_pkg::ppo_rel_t'(wopt[`PPO_REL_LSB +: 2]);
          if (wopt[`PPO_RLS_LSB +: 2] != 2'h3)
            st_d.rls = ppo_pkg::ppo_rls_t'(wopt[`PPO_RLS_LSB +: 2]);
          st_d.rad = ppo_pkg::ppo_rad_t'(wopt[`PPO_RAD_LSB +: 2]);
        end
        else
          st_d.rdata = {16'h0000, st_q.opt};
      end
      else
        st_d.rerr = 1'b1;
    end
    // new-setpoint handshake
    unique case (st_q.sp)
      ppo_pkg::PPO_SP_IDLE:
      begin
        if (acc)
        begin
          st_d.sp = ppo_pkg::PPO_SP_HELD;
          st_d.ack = 1'b1;
          st_d.dem = t_abs;
          st_d.dir = t_dir;
          st_d.via = t_via;
          st_d.prev = t_abs;
          st_d.prev_vld = 1'b1;
        end
      end
      ppo_pkg::PPO_SP_HELD:
      begin
        if (!ctrl_new_sp_i)
        begin
          st_d.sp = ppo_pkg::PPO_SP_IDLE;
          st_d.ack = 1'b0;
        end
        else if (st_q.rls == ppo_pkg::PPO_RLS_ASAP ||
                 (st_q.rls == ppo_pkg::PPO_RLS_REACH && target_reached_i))
        begin
          st_d.clr = 1'b1;
          st_d.sp = ppo_pkg::PPO_SP_REL;
        end
      end
      ppo_pkg::PPO_SP_REL:
      begin
        // acknowledge drops one cycle after the clear request, without waiting for the bit to fall
        st_d.sp = ppo_pkg::PPO_SP_IDLE;
        st_d.ack = 1'b0;
      end
      default:
      begin
        st_d.sp = ppo_pkg::PPO_SP_IDLE;
        st_d.ack = 1'b0;
      end
    endcase
  end

  // state register, frozen while clock enable is low
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_q <= '0;
      st_q.div <= {FB{`PPO_DIV_RST}};
      st_q.opt <= OPT_RST;
      st_q.rel <= ppo_pkg::ppo_rel_t'(OPT_RST[`PPO_REL_LSB +: 2]);
      st_q.rls <= ppo_pkg::ppo_rls_t'(OPT_RST[`PPO_RLS_LSB +: 2]);
      st_q.rad <= ppo_pkg::ppo_rad_t'(OPT_RST[`PPO_RAD_LSB +: 2]);
      st_q.start <= 1'b1;
    end
    else if (ce_i)
      st_q <= st_d;
  end

  assign od_ack_o = st_q.rack;
  assign od_err_o = st_q.rerr;
  assign od_rdata_o = st_q.rdata;
  assign sp_ack_o = st_q.ack;
  assign nsp_clear_o = st_q.clr;
  assign demand_target_o = st_q.dem;
  assign dir_pos_o = st_q.dir;
  assign via_limit_o = st_q.via;
  assign feed_const_o = st_q.feed;
  assign gear_ratio_o = st_q.gear;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i || !ce_i);

  AST_COUNT_READ: assert property (
    od_req_i && !od_we_i && hit_div && od_sub_i == `PPO_SUB_COUNT
    |=> od_ack_o && !od_err_o && od_rdata_o == 32'(FB))
    else $error("count entry read wrong");
  AST_COUNT_RO: assert property (
    od_req_i && od_we_i && hit_div && od_sub_i == `PPO_SUB_COUNT |=> od_err_o)
    else $error("count entry write not refused");
  AST_FEED_STORE: assert property (
    div_done && st_q.job == '0 |=> feed_const_o[0] == $past(div_quo))
    else $error("feed constant not stored");
  AST_OPT_READBACK: assert property (
    od_req_i && od_we_i && hit_opt && od_sub_i == `PPO_SUB_OPT
    ##1 !od_req_i
    ##1 od_req_i && !od_we_i && hit_opt && od_sub_i == `PPO_SUB_OPT
    |=> od_rdata_o == {16'h0000, $past(od_wdata_i[15:0], 3)})
    else $error("option word readback wrong");
  AST_RSV_KEEP: assert property (
    od_req_i && od_we_i && hit_opt && wopt[`PPO_REL_LSB +: 2] == 2'h3
    |=> $stable(st_q.rel))
    else $error("reserved code became active");
  AST_NO_SELF_CLEAR: assert property (
    st_q.sp == ppo_pkg::PPO_SP_HELD && st_q.rls == ppo_pkg::PPO_RLS_NONE
    |=> !nsp_clear_o)
    else $error("self clear in normal handshake");
  AST_REACH_CLEAR: assert property (
    st_q.sp == ppo_pkg::PPO_SP_HELD && st_q.rls == ppo_pkg::PPO_RLS_REACH
    && ctrl_new_sp_i && target_reached_i
    |=> nsp_clear_o && sp_ack_o ##1 !sp_ack_o && !nsp_clear_o)
    else $error("release at target missing");
  AST_ASAP_CLEAR: assert property (
    st_q.sp == ppo_pkg::PPO_SP_HELD && st_q.rls == ppo_pkg::PPO_RLS_ASAP
    && ctrl_new_sp_i |=> nsp_clear_o ##1 !sp_ack_o)
    else $error("early release missing");
  AST_PREV_ZERO: assert property (
    acc && ctrl_rel_i && st_q.rel == ppo_pkg::PPO_REL_PREV && !st_q.prev_vld
    && target_pos_i <= range_max_i && target_pos_i >= range_min_i
    |=> demand_target_o == $past(target_pos_i) && sp_ack_o)
    else $error("relative to zero wrong");
  AST_NEG_DIR: assert property (
    acc && st_q.rad == ppo_pkg::PPO_RAD_NEG |=> !dir_pos_o)
    else $error("negative-only moved positive");
  AST_POS_DIR: assert property (
    acc && st_q.rad == ppo_pkg::PPO_RAD_POS |=> dir_pos_o)
    else $error("positive-only moved negative");

  COV_ACCEPT: cover property (acc);
  COV_RELEASE: cover property (nsp_clear_o ##1 !sp_ack_o);
  COV_OPT_WRITE: cover property (od_req_i && od_we_i && hit_opt);
endmodule
`default_nettype wire

/* tb/ppo_master_model.sv */
`timescale 1ns/1ns
`default_nettype none
// fieldbus master: dictionary accesses and the new-setpoint bit
module ppo_master_model (
  input wire logic ref_clk_i,
  input wire logic od_ack_i,
  input wire logic od_err_i,
  input wire logic [31:0] od_rdata_i,
  input wire logic nsp_clear_i,
  output logic od_req_o,
  output logic od_we_o,
  output logic [15:0] od_index_o,
  output logic [7:0] od_sub_o,
  output logic [31:0] od_wdata_o,
  output logic ctrl_new_sp_o
);
  initial
  begin
    od_req_o = 1'b0;
    od_we_o = 1'b0;
    od_index_o = 16'h0000;
    od_sub_o = 8'h00;
    od_wdata_o = 32'h00000000;
    ctrl_new_sp_o = 1'b0;
  end
  // one access; released lines show inverted junk, not the old value
  task automatic od_access(input logic w, input logic [15:0] i, input logic [7:0] s,
                           input logic [31:0] d, output logic a, output logic e,
                           output logic [31:0] r);
    @(posedge ref_clk_i);
    od_req_o <= 1'b1;
    od_we_o <= w;
    od_index_o <= i;
    od_sub_o <= s;
    od_wdata_o <= d;
    @(posedge ref_clk_i);
    od_req_o <= 1'b0;
    od_index_o <= ~i;
    od_sub_o <= ~s;
    od_wdata_o <= ~d;
    #1;
    a = od_ack_i;
    e = od_err_i;
    r = od_rdata_i;
  endtask
  // bit must be seen low before the rising edge counts
  task automatic raise();
    @(posedge ref_clk_i);
    ctrl_new_sp_o <= 1'b0;
    @(posedge ref_clk_i);
    ctrl_new_sp_o <= 1'b1;
  endtask
  // normal handshake: master clears the bit itself
  task automatic drop();
    @(posedge ref_clk_i);
    ctrl_new_sp_o <= 1'b0;
  endtask
  // the device asks for the bit to be cleared
  always @(posedge ref_clk_i)
    if (nsp_clear_i)
      ctrl_new_sp_o <= 1'b0;
endmodule
`default_nettype wire

/* tb/profile_position_options_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) \
  begin \
    cmp_count++; \
    if ((a) !== (b)) \
    begin \
      failures++; \
      $display("Error %0t: got %h want %h", $time, a, b); \
    end \
  end
module profile_position_options_tb;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic pp = 1'b1, rel = 1'b0, rdy = 1'b1, reach = 1'b0, ce = 1'b1;
  logic req, we, ack, err, nsp, spa, clr, dpos, via, a, e;
  logic [15:0] idx;
  logic [7:0] sub;
  logic [31:0] wd, rd, r;
  logic signed [31:0] tgt = '0, ramp = '0, act = '0, dem;
  logic [2:0][31:0] feed = '0, mrev = '0, drev = '0, fc, gr, fx, gx;
  int failures = 0;
  int cmp_count = 0;
  int rel_a = 1, rls_a = 0, rad_a = 0, saw = 0;
  longint prev_m = 0;
  bit prev_v = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i)
    if (clr)
      saw <= 1;
  ppo_options #(.FB(3)) ppo_options_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .ce_i(ce), .od_req_i(req), .od_we_i(we), .od_index_i(idx), .od_sub_i(sub),
    .od_wdata_i(wd), .od_ack_o(ack), .od_err_o(err), .od_rdata_o(rd), .pp_mode_i(pp),
    .ctrl_new_sp_i(nsp), .ctrl_rel_i(rel), .sp_ready_i(rdy), .target_reached_i(reach),
    .target_pos_i(tgt), .ramp_out_i(ramp), .actual_pos_i(act), .range_min_i(-32'sd1000),
    .range_max_i(32'sd999), .feed_i(feed), .motor_rev_i(mrev), .drive_rev_i(drev),
    .sp_ack_o(spa), .nsp_clear_o(clr), .demand_target_o(dem), .dir_pos_o(dpos),
    .via_limit_o(via), .feed_const_o(fc), .gear_ratio_o(gr));
  ppo_master_model ppo_master_model_inst (.ref_clk_i(ref_clk_i), .od_ack_i(ack),
    .od_err_i(err), .od_rdata_i(rd), .nsp_clear_i(clr), .od_req_o(req), .od_we_o(we),
    .od_index_o(idx), .od_sub_o(sub), .od_wdata_o(wd), .ctrl_new_sp_o(nsp));
  task automatic report_and_stop();
    $display("failures=%0d cmp_count=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // access plus check of answer; data reads 0 on writes and refusals
  task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
                     input logic [31:0] d, input logic [31:0] x, input logic xe);
    ppo_master_model_inst.od_access(w, i, s, d, a, e, r);
    `CHK(a, 1'b1)
    `CHK(e, xe)
    `CHK(r, x)
  endtask
  // reserved field codes keep the mode that was active
  task automatic wopt(input logic [31:0] v);
    acc(1'b1, 16'h60EE + 16'h0004, 8'h00, v, 32'h0, 1'b0);
    acc(1'b0, 16'h60F2, 8'h00, 32'h0, {16'h0, v[15:0]}, 1'b0);
    if (v[1:0] != 2'h3)
      rel_a = v[1:0];
    if (v[5:4] != 2'h3)
      rls_a = v[5:4];
    rad_a = v[7:6];
  endtask
  task automatic wt(input logic lvl, input int n);
    int k;
    for (k = 0; k < n; k++)
    begin
      @(posedge ref_clk_i);
      #1;
      if (spa === lvl)
        break;
    end
    if (k == n)
    begin
      failures++;
      $display("Error %0t: wait ran out", $time);
      report_and_stop();
    end
  endtask
  function automatic longint rnd(input int n);
    return longint'($urandom % n);
  endfunction
  // one setpoint with expected target, direction and handshake end
  task automatic move(input logic rr, input longint t, input longint rp, input longint ac);
    longint b, x;
    logic xd, xv, fold;
    @(posedge ref_clk_i);
    tgt <= t[31:0];
    rel <= rr;
    ramp <= rp[31:0];
    act <= ac[31:0];
    b = rel_a == 0 ? (prev_v ? prev_m : 0) : rel_a == 1 ? rp : ac;
    x = rr ? b + t : t;
    fold = x > 999 || x < -1000;
    x = x > 999 ? x - 2000 : x < -1000 ? x + 2000 : x;
    xd = rad_a == 1 ? 1'b0 : rad_a == 2 ? 1'b1 : rad_a == 3 ?
      (((x - ac) % 2000 + 2000) % 2000) * 2 < 2000 : x >= ac;
    xv = rad_a == 1 ? x > ac : rad_a == 2 ? x < ac : rad_a == 3 ?
      (xd ? x < ac : x > ac) : fold;
    saw = 0;
    ppo_master_model_inst.raise();
    wt(1'b1, 10);
    `CHK(dem, x[31:0])
    if (!fold)
    begin
      `CHK(dpos, xd)
      `CHK(via, xv)
    end
    prev_m = x;
    prev_v = 1;
    if (rls_a == 2)
    begin
      @(posedge ref_clk_i);
      #1;
      `CHK(clr, 1'b1)
    end
    else
    begin
      repeat (4) @(posedge ref_clk_i);
      #1;
      `CHK(spa, 1'b1)
      `CHK(saw, 0)
      if (rls_a == 1)
        @(posedge ref_clk_i) reach <= 1'b1;
      else
        ppo_master_model_inst.drop();
    end
    wt(1'b0, 8);
    `CHK(saw, int'(rls_a != 0))
    @(posedge ref_clk_i) reach <= 1'b0;
  endtask
  initial
  begin
    void'($urandom(32'h6C60));
    repeat (8) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    acc(1'b0, 16'h60EE, 8'h00, 32'h0, 32'h3, 1'b0);
    acc(1'b0, 16'h60F2, 8'h00, 32'h0, 32'h1, 1'b0);
    acc(1'b1, 16'h60EE, 8'h00, 32'h5, 32'h0, 1'b1);
    acc(1'b0, 16'h60EE, 8'h04, 32'h0, 32'h0, 1'b1);
    acc(1'b0, 16'h6000, 8'h00, 32'h0, 32'h0, 1'b1);
    acc(1'b0, 16'h60F2, 8'h01, 32'h0, 32'h0, 1'b1);
    // clock enable low: the request is not taken and gets no answer
    @(posedge ref_clk_i) ce <= 1'b0;
    ppo_master_model_inst.od_access(1'b0, 16'h60F2, 8'h00, 32'h0, a, e, r);
    `CHK(a, 1'b0)
    @(posedge ref_clk_i) ce <= 1'b1;
    // divisors of sub n+1 land on entry n, sub 1 being the sensorless one
    for (int n = 0; n < 3; n++)
    begin
      logic [31:0] dv;
      dv = 32'(rnd(1000) + 1);
      acc(1'b0, 16'h60EE, 8'(n + 1), 32'h0, 32'h1, 1'b0);
      acc(1'b1, 16'h60EE, 8'(n + 1), dv, 32'h0, 1'b0);
      acc(1'b0, 16'h60EE, 8'(n + 1), 32'h0, dv, 1'b0);
      fx[n] = $urandom;
      gx[n] = $urandom;
      @(posedge ref_clk_i);
      feed[n] <= fx[n];
      mrev[n] <= gx[n];
      drev[n] <= n == 2 ? 32'h0 : 32'(n + 7);
      fx[n] = fx[n] / dv;
      gx[n] = n == 2 ? 32'hFFFFFFFF : gx[n] / 32'(n + 7);
    end
    for (int k = 0; k < 1000 && (fc !== fx || gr !== gx); k++)
      @(posedge ref_clk_i);
    for (int n = 0; n < 3; n++)
    begin
      `CHK(fc[n], fx[n])
      `CHK(gr[n], gx[n])
    end
    // rising bit outside the mode or while not ready is ignored
    for (int j = 0; j < 2; j++)
    begin
      @(posedge ref_clk_i);
      pp <= 1'(j);
      rdy <= 1'(1 - j);
      ppo_master_model_inst.raise();
      repeat (4) @(posedge ref_clk_i);
      #1;
      `CHK(spa, 1'b0)
      ppo_master_model_inst.drop();
      @(posedge ref_clk_i);
      pp <= 1'b1;
      rdy <= 1'b1;
    end
    for (int i = 0; i < 12; i++)
      begin
        wopt({16'h0, 8'($urandom), 2'(i / 3), 2'((i / 3 + i) % 3), 2'h0, 2'(i % 3)});
        move(i % 4 != 3, i % 4 != 3 ? rnd(400) - 200 : rnd(2000) - 1000,
             rnd(1000) - 500, rnd(1000) - 500);
      end
    wopt(32'hFFFF80B3);
    move(1'b1, rnd(400) - 200, rnd(1000) - 500, rnd(1000) - 500);
    wopt(32'h00000002);
    move(1'b1, 300, 0, 900);
    report_and_stop();
  end
endmodule
`default_nettype wire
